// ---- mnpc_device.sv ----
// Controller end: transmit clock select, termination, loopback, compression, reject
`timescale 1ns/1ps
module mnpc_device
  import mnpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic dcr_write,
  input wire logic [CFG_W-1:0] dcr_data,
  input wire logic data_config_reg_second_write,
  input wire logic [CFG_W-1:0] data_config_reg_second_data,
  input wire logic bus_master,
  input wire logic bus_ordering_select,
  input wire logic async_bus_mode,
  input wire logic cycle_active,
  input wire logic oscillator_input,
  input wire logic carrier_sense_indication,
  input wire logic address_filter_match,
  output logic cycle_terminate,
  output logic mac_tx_clock,
  output logic mac_tx_clock_rise,
  output logic packet_discard,
  output logic [CFG_W-1:0] data_config_reg,
  output logic [CFG_W-1:0] data_config_reg_second,
  mnpc_link_if.device link
);

  // Counter increment helper, cut to the counter width
  function automatic logic [BIT_CNT_W-1:0] mnpc_inc(input logic [BIT_CNT_W-1:0] v);
    mnpc_inc = BIT_CNT_W'(v + 1'b1);
  endfunction : mnpc_inc

  logic [CFG_W-1:0] dcr_reg;
  logic [CFG_W-1:0] data_config_reg_second_reg;
  logic dcr_written_reg;
  logic comp_written_reg;
  logic master_seen_reg;
  logic tx_int_reg;
  logic txc_s1_reg;
  logic txc_s2_reg;
  logic mac_tx_reg;
  logic mac_tx_prev_reg;
  logic term_reg;
  logic cycle_term_reg;
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_s3_reg;
  logic rej_s1_reg;
  logic rej_s2_reg;
  logic carrier_prev_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_next;
  logic [REJECT_CNT_W-1:0] low_cnt_reg;
  logic [REJECT_CNT_W-1:0] low_cnt_next;
  logic reject_pending_reg;
  logic discard_reg;
  logic comp_reg;
  logic comp_next;
  mnpc_comp_state_t comp_state_reg;
  mnpc_comp_state_t comp_state_next;

  // Decoded configuration fields
  wire ext_sel = dcr_reg[DCR_EXT_BIT];
  wire extended_bus_option_sel = dcr_reg[DCR_EXTENDED_BUS_OPTION_BIT];
  wire loop_en = dcr_reg[DCR_LOOP_BIT];
  wire user2_val = data_config_reg_second_reg[DATA_CONFIG_REG_SECOND_USER2_BIT];
  wire comp_en = data_config_reg_second_reg[DATA_CONFIG_REG_SECOND_COMP_EN_BIT];
  wire comp_on_miss = data_config_reg_second_reg[DATA_CONFIG_REG_SECOND_COMP_MISS_BIT];
  // Termination mode frees the shared pin for the far end
  wire term_mode = bus_ordering_select & async_bus_mode; // [RL6]
  wire use_ext_clock = ext_sel & ~term_mode;

  // Edge events on the synchronised receive clock and carrier
  wire rx_rise = rx_s2_reg & ~rx_s3_reg;
  wire carrier_fall = carrier_prev_reg & ~carrier_sense_indication;
  wire tx_rise = mac_tx_reg & ~mac_tx_prev_reg;
  wire filter_hit = address_filter_match ^ comp_on_miss; // [RL10]
  wire at_comp_bit = rx_rise && (bit_cnt_reg == BIT_CNT_W'(COMP_BIT_INDEX - 1));
  wire reject_set = rx_rise & carrier_sense_indication & ~rej_s2_reg
                    & (low_cnt_reg == REJECT_CNT_W'(REJECT_MIN_EDGES - 1));

  // Configuration registers and their first-write flags
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dcr_reg <= CFG_RESET;
      data_config_reg_second_reg <= CFG_RESET;
      dcr_written_reg <= 1'b0;
      comp_written_reg <= 1'b0;
      master_seen_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (dcr_write)
      begin
        dcr_reg <= dcr_data;
        dcr_written_reg <= 1'b1; // [RL1]
      end
      if (data_config_reg_second_write)
      begin
        data_config_reg_second_reg <= data_config_reg_second_data;
        comp_written_reg <= 1'b1; // [RL11]
      end
      if (bus_master)
        master_seen_reg <= 1'b1; // [RL9]
    end
  end

  // Internal transmit clock: toggle on every oscillator tick, halving its rate
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      tx_int_reg <= 1'b0;
    else if (ce && oscillator_input)
      tx_int_reg <= ~tx_int_reg; // [RL2]
  end

  // Pin clock synchroniser and MAC clock select
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      txc_s1_reg <= 1'b0;
      txc_s2_reg <= 1'b0;
      mac_tx_reg <= 1'b0;
      mac_tx_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      txc_s1_reg <= link.txc_pin;
      txc_s2_reg <= txc_s1_reg;
      mac_tx_reg <= use_ext_clock ? txc_s2_reg : tx_int_reg; // [RL3] [RL4]
      mac_tx_prev_reg <= mac_tx_reg;
    end
  end

  // Termination sample and cycle end pulse
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      term_reg <= 1'b1;
      cycle_term_reg <= 1'b0;
    end
    else if (ce)
    begin
      term_reg <= link.txc_pin; // [RL5]
      cycle_term_reg <= bus_master & cycle_active & term_mode & ~term_reg; // [RL5] [RL6]
    end
  end

  // Receive clock, reject and carrier sampling
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_s3_reg <= 1'b0;
      rej_s1_reg <= 1'b1;
      rej_s2_reg <= 1'b1;
      carrier_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      rx_s1_reg <= link.rx_bit_clock;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      rej_s1_reg <= link.packet_reject_in_n; // [RL16]
      rej_s2_reg <= rej_s1_reg;
      carrier_prev_reg <= carrier_sense_indication;
    end
  end

  // Bit position and consecutive-low counters
  always_comb
  begin
    bit_cnt_next = bit_cnt_reg;
    low_cnt_next = low_cnt_reg;
    if (!carrier_sense_indication)
    begin
      bit_cnt_next = '0;
      low_cnt_next = '0;
    end
    else if (rx_rise)
    begin
      if (bit_cnt_reg != {BIT_CNT_W{1'b1}})
        bit_cnt_next = mnpc_inc(bit_cnt_reg);
      if (rej_s2_reg)
        low_cnt_next = '0; // [RL16]
      else if (low_cnt_reg != REJECT_CNT_W'(REJECT_MIN_EDGES))
        low_cnt_next = REJECT_CNT_W'(low_cnt_reg + 1'b1); // [RL14]
    end
  end

  // Reject latch and discard pulse at end of reception
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_reg <= '0;
      low_cnt_reg <= '0;
      reject_pending_reg <= 1'b0;
      discard_reg <= 1'b0;
    end
    else if (ce)
    begin
      bit_cnt_reg <= bit_cnt_next;
      low_cnt_reg <= low_cnt_next;
      discard_reg <= carrier_fall & (reject_pending_reg | reject_set); // [RL14] [RL15]
      if (reject_set)
        reject_pending_reg <= 1'b1; // [RL15]
      else if (carrier_fall)
        reject_pending_reg <= 1'b0;
    end
  end

  // Compression state machine
  always_comb
  begin
    comp_state_next = comp_state_reg;
    comp_next = comp_reg;
    case (comp_state_reg)
      MNPC_COMP_IDLE:
      begin
        comp_next = 1'b0;
        if (carrier_sense_indication)
          comp_state_next = MNPC_COMP_COUNT;
      end
      MNPC_COMP_COUNT:
      begin
        if (!carrier_sense_indication)
          comp_state_next = MNPC_COMP_IDLE;
        else if (at_comp_bit)
        begin
          comp_state_next = MNPC_COMP_ON;
          comp_next = comp_en & filter_hit; // [RL12] [RL10]
        end
      end
      MNPC_COMP_ON:
      begin
        if (carrier_fall)
          comp_state_next = MNPC_COMP_DROP;
      end
      MNPC_COMP_DROP:
      begin
        if (tx_rise)
        begin
          comp_next = 1'b0; // [RL13]
          comp_state_next = MNPC_COMP_IDLE;
        end
      end
      default:
      begin
        comp_state_next = MNPC_COMP_IDLE;
        comp_next = 1'b0;
      end
    endcase
  end

  // Compression state register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      comp_state_reg <= MNPC_COMP_IDLE;
      comp_reg <= 1'b0;
    end
    else if (ce)
    begin
      comp_state_reg <= comp_state_next;
      comp_reg <= comp_next;
    end
  end

  // Shared pin drivers
  assign link.txc_dev_out = tx_int_reg; // [RL3]
  assign link.txc_dev_oe = dcr_written_reg & ~ext_sel & ~term_mode; // [RL1] [RL3]
  assign link.lbk_out = extended_bus_option_sel ? user2_val : loop_en; // [RL7] [RL8]
  assign link.lbk_oe = dcr_written_reg & (~extended_bus_option_sel | master_seen_reg); // [RL1] [RL9]
  assign link.comp_out = comp_reg;
  assign link.comp_oe = comp_written_reg; // [RL11]

  // User-side outputs
  assign cycle_terminate = cycle_term_reg;
  assign mac_tx_clock = mac_tx_reg;
  assign mac_tx_clock_rise = tx_rise;
  assign packet_discard = discard_reg;
  assign data_config_reg = dcr_reg;
  assign data_config_reg_second = data_config_reg_second_reg;

endmodule : mnpc_device

// ---- mnpc_far.sv ----
// Far end: external clock source, termination driver, reject requester
`timescale 1ns/1ps
module mnpc_far
  import mnpc_pkg::*;
#(
  parameter int RX_HALF = RX_HALF_CYCLES,
  parameter int REJECT_EDGES = REJECT_MIN_EDGES + 1
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic drive_tx_clock,
  input wire logic terminate_request,
  input wire logic reject_request,
  output logic reject_busy,
  output logic compression_seen,
  output logic loopback_seen,
  mnpc_link_if.far link
);

  logic [7:0] rx_div_reg;
  logic rx_clk_reg;
  logic rx_clk_prev_reg;
  logic tx_clk_reg;
  logic [3:0] rej_cnt_reg;
  logic rej_low_reg;
  logic comp_seen_reg;
  logic lbk_seen_reg;

  wire rx_div_end = (rx_div_reg == 8'(RX_HALF - 1));
  wire rx_rise = rx_clk_reg & ~rx_clk_prev_reg;

  // Receive clock and own transmit clock from dividers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_div_reg <= 8'h00;
      rx_clk_reg <= 1'b0;
      rx_clk_prev_reg <= 1'b0;
      tx_clk_reg <= 1'b0;
    end
    else if (ce)
    begin
      rx_div_reg <= rx_div_end ? 8'h00 : 8'(rx_div_reg + 1'b1);
      if (rx_div_end)
        rx_clk_reg <= ~rx_clk_reg;
      rx_clk_prev_reg <= rx_clk_reg;
      tx_clk_reg <= ~tx_clk_reg; // [RL4]
    end
  end

  // Reject request held low for a set count of receive clock rises
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rej_cnt_reg <= 4'h0;
      rej_low_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (!rej_low_reg && reject_request)
      begin
        rej_low_reg <= 1'b1; // [RL15]
        rej_cnt_reg <= 4'h0;
      end
      else if (rej_low_reg && rx_rise)
      begin
        if (rej_cnt_reg == 4'(REJECT_EDGES - 1))
          rej_low_reg <= 1'b0; // [RL14]
        rej_cnt_reg <= 4'(rej_cnt_reg + 1'b1);
      end
    end
  end

  // Observed pin levels
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      comp_seen_reg <= 1'b0;
      lbk_seen_reg <= 1'b0;
    end
    else if (ce)
    begin
      comp_seen_reg <= link.comp_pin;
      lbk_seen_reg <= link.lbk_pin;
    end
  end

  // Pin drivers: termination pulls low, otherwise own clock when selected
  assign link.txc_far_oe = drive_tx_clock | terminate_request; // [RL6]
  assign link.txc_far_out = terminate_request ? 1'b0 : tx_clk_reg; // [RL4]
  assign link.packet_reject_in_n = ~rej_low_reg; // [RL14]
  assign link.rx_bit_clock = rx_clk_reg;
  assign reject_busy = rej_low_reg;
  assign compression_seen = comp_seen_reg;
  assign loopback_seen = lbk_seen_reg;

endmodule : mnpc_far

// ---- mnpc_link_if.sv ----
// Pin bundle between the controller and its far-end partner
`timescale 1ns/1ps
interface mnpc_link_if;
  logic txc_dev_out;
  logic txc_dev_oe;
  logic txc_far_out;
  logic txc_far_oe;
  logic txc_pin;
  logic lbk_out;
  logic lbk_oe;
  logic lbk_pin;
  logic comp_out;
  logic comp_oe;
  logic comp_pin;
  logic packet_reject_in_n;
  logic rx_bit_clock;

  // Wire levels from the enables, pulled high when nobody drives
  assign txc_pin = txc_dev_oe ? txc_dev_out : (txc_far_oe ? txc_far_out : 1'b1);
  assign lbk_pin = lbk_oe ? lbk_out : 1'b1;
  assign comp_pin = comp_oe ? comp_out : 1'b1;

  modport device (
    output txc_dev_out,
    output txc_dev_oe,
    input txc_pin,
    output lbk_out,
    output lbk_oe,
    output comp_out,
    output comp_oe,
    input packet_reject_in_n,
    input rx_bit_clock
  );

  modport far (
    output txc_far_out,
    output txc_far_oe,
    input txc_pin,
    input lbk_pin,
    input comp_pin,
    output packet_reject_in_n,
    output rx_bit_clock
  );
endinterface : mnpc_link_if

// ---- mnpc_pkg.sv ----
// Constants shared by both ends of the network-side pin control link
// How it works
// RL1: Shared pins float until first configuration write
// RL2: Internal transmit clock is oscillator divided by two
// RL3: Internal clock feeds MAC and drives pin
// RL4: External select uses far-end clock for shifting
// RL5: Termination pin sampled synchronously while bus master
// RL6: Termination used only in async ordering mode
// RL7: Loopback indicator high while loopback enabled
// RL8: Extended option turns pin into user output
// RL9: User output floats until first bus mastership
// RL10: Compression on filter match or mismatch, selectable
// RL11: Second config bits 1,2 control compression pin
// RL12: Compression asserts after seventh byte fourth bit
// RL13: Compression drops one transmit clock after carrier
// RL14: Reject low two receive clocks discards packet
// RL15: Reject honoured up to second-last bit
// RL16: Reject synchronised, two low edges qualify
package mnpc_pkg;
  // Clock rates and the transmit divider
  localparam int CLOCK_HZ = 10_000_000;
  localparam int OSC_HZ = 20_000_000;
  localparam int TX_BIT_HZ = 10_000_000;
  localparam int TX_DIV = OSC_HZ / TX_BIT_HZ;
  localparam int TX_TOGGLE_TICKS = TX_DIV / 2;
  // Receive frame position where compression starts
  localparam int COMP_BYTE = 7;
  localparam int COMP_BIT = 4;
  localparam int COMP_BIT_INDEX = (COMP_BYTE - 1) * 8 + COMP_BIT;
  localparam int BIT_CNT_W = 7;
  // Reject qualification
  localparam int REJECT_MIN_EDGES = 2;
  localparam int REJECT_CNT_W = 2;
  // Configuration word width and field positions
  localparam int CFG_W = 16;
  localparam int DCR_EXT_BIT = 0;
  localparam int DCR_EXTENDED_BUS_OPTION_BIT = 1;
  localparam int DCR_LOOP_BIT = 2;
  localparam int DATA_CONFIG_REG_SECOND_USER2_BIT = 0;
  localparam int DATA_CONFIG_REG_SECOND_COMP_EN_BIT = 1;
  localparam int DATA_CONFIG_REG_SECOND_COMP_MISS_BIT = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
  // Far-end receive clock half period in clock cycles
  localparam int RX_HALF_CYCLES = 1;
  // Compression state machine, Gray coded
  typedef enum logic [1:0] {
    MNPC_COMP_IDLE = 2'b00,
    MNPC_COMP_COUNT = 2'b01,
    MNPC_COMP_ON = 2'b11,
    MNPC_COMP_DROP = 2'b10
  } mnpc_comp_state_t;
endpackage : mnpc_pkg

// ---- mnpc_properties.sv ----
// Concurrent checks on the pin link between the two ends
`timescale 1ns/1ps
module mnpc_properties
  import mnpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic dcr_write,
  input wire logic [CFG_W-1:0] dcr_data,
  input wire logic data_config_reg_second_write,
  input wire logic bus_master,
  input wire logic bus_ordering_select,
  input wire logic async_bus_mode,
  input wire logic cycle_active,
  input wire logic carrier_sense_indication,
  input wire logic cycle_terminate,
  input wire logic packet_discard,
  input wire logic txc_dev_oe,
  input wire logic txc_pin,
  input wire logic lbk_out,
  input wire logic lbk_oe,
  input wire logic comp_out,
  input wire logic comp_oe,
  input wire logic packet_reject_in_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Mode decode used by several checks
  wire term_mode = bus_ordering_select && async_bus_mode;
  wire term_cond = bus_master && cycle_active && term_mode;
  wire dcr_take = ce && dcr_write;

  // Pin enables and the causes behind them
  a_float_after_reset: assert property ($fell(rst) |-> !(txc_dev_oe || lbk_oe || comp_oe))
    else $error("shared pin driven right after reset");
  a_loop_follows: assert property (dcr_take && !dcr_data[DCR_EXTENDED_BUS_OPTION_BIT]
    |=> lbk_oe && lbk_out == $past(dcr_data[DCR_LOOP_BIT]))
    else $error("loopback pin does not follow the loop bit");
  a_txc_internal: assert property (dcr_take && !dcr_data[DCR_EXT_BIT] && !term_mode
    |=> txc_dev_oe || term_mode)
    else $error("internal transmit clock not driven");
  a_txc_external: assert property (dcr_take && dcr_data[DCR_EXT_BIT] |=> !txc_dev_oe)
    else $error("transmit clock pin driven with external select");
  a_comp_oe_holds: assert property (comp_oe |=> comp_oe)
    else $error("compression pin released");
  a_comp_oe_cause: assert property ($rose(comp_oe) |-> $past(data_config_reg_second_write))
    else $error("compression pin driven without a write");

  // Termination pulse tied to the sampled pin and the mode
  a_term_cause: assert property (!$past(rst) && !$past(rst, 2)
    |-> cycle_terminate == (!$past(txc_pin, 2) && $past(term_cond)))
    else $error("termination pulse does not match its cause");

  // Compression and reject timing
  a_comp_drop: assert property ($fell(carrier_sense_indication) |-> ##[1:6] !comp_out)
    else $error("compression still high after carrier fell");
  a_reject_hold: assert property ($fell(packet_reject_in_n) |-> !packet_reject_in_n [*3])
    else $error("reject line released too early");
  a_discard_end: assert property (packet_discard
    |-> !carrier_sense_indication ##1 !packet_discard)
    else $error("discard outside end of frame");

  // Main scenarios reached
  c_term: cover property (cycle_terminate);
  c_discard: cover property (packet_discard);
  c_comp: cover property (comp_oe && $rose(comp_out));
endmodule : mnpc_properties

// ---- mnpc_tb_top.sv ----
// Self-checking bench for both ends of the pin link
`timescale 1ns/1ps
module mnpc_tb_top
  import mnpc_pkg::*;
;
  logic clock = 0;
  logic rst = 1;
  logic ce = 1;
  logic dcr_write = 0;
  logic data_config_reg_second_write = 0;
  logic [CFG_W-1:0] dcr_data = 16'h0000;
  logic [CFG_W-1:0] data_config_reg_second_data = 16'h0000;
  logic bus_master = 0;
  logic bus_ordering_select = 0;
  logic async_bus_mode = 0;
  logic cycle_active = 0;
  logic oscillator_input = 1;
  logic carrier_sense_indication = 0;
  logic address_filter_match = 0;
  logic drive_tx_clock = 0;
  logic terminate_request = 0;
  logic reject_request = 0;
  logic comp_prev = 0;
  logic reject_busy, compression_seen, loopback_seen;
  logic cycle_terminate, mac_tx_clock, mac_tx_clock_rise, packet_discard;
  logic [CFG_W-1:0] data_config_reg, data_config_reg_second;
  int num_errors = 0;
  int checks = 0;
  int seed = 63;
  logic [1:0] notes[$];

  mnpc_link_if link();
  mnpc_device mnpc_device_inst (.clock, .rst, .ce, .dcr_write, .dcr_data, .data_config_reg_second_write,
    .data_config_reg_second_data, .bus_master, .bus_ordering_select, .async_bus_mode, .cycle_active,
    .oscillator_input, .carrier_sense_indication, .address_filter_match, .cycle_terminate,
    .mac_tx_clock, .mac_tx_clock_rise, .packet_discard, .data_config_reg,
    .data_config_reg_second, .link(link));
  mnpc_far mnpc_far_inst (.clock, .rst, .ce, .drive_tx_clock, .terminate_request,
    .reject_request, .reject_busy(reject_busy), .compression_seen(compression_seen),
    .loopback_seen(loopback_seen), .link(link));
  mnpc_properties mnpc_properties_inst (.clock, .rst, .ce, .dcr_write, .dcr_data,
    .data_config_reg_second_write, .bus_master, .bus_ordering_select, .async_bus_mode, .cycle_active,
    .carrier_sense_indication, .cycle_terminate, .packet_discard,
    .txc_dev_oe(link.txc_dev_oe), .txc_pin(link.txc_pin), .lbk_out(link.lbk_out),
    .lbk_oe(link.lbk_oe), .comp_out(link.comp_out), .comp_oe(link.comp_oe),
    .packet_reject_in_n(link.packet_reject_in_n));

  // Clock of 100 ns period
  always #50 clock = !clock;

  // Prints the counts and the verdict, then stops
  task automatic give_verdict;
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // Compares one level
  task automatic chk(input logic exp, input logic act);
    checks++;
    if (act !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: level %b, expected %b", $time, act, exp);
    end
  endtask : chk

  // Matches a seen pulse with the oldest note
  task automatic take(input logic [1:0] code);
    checks++;
    if (notes.size() == 0 || notes[0] !== code)
    begin
      num_errors++;
      $display("unexpected at %0t: pulse kind %0d", $time, code);
    end
    else
      void'(notes.pop_front());
  endtask : take

  // Watches the result pulses
  always @(negedge clock)
  begin
    if (cycle_terminate === 1'h1)
      take(2'h0);
    if (packet_discard === 1'h1)
      take(2'h1);
    if (link.comp_oe && link.comp_out && !comp_prev)
      take(2'h2);
    comp_prev = link.comp_oe && link.comp_out;
  end

  // Writes one configuration register and reads it back
  task automatic wr(input logic sel, input logic [CFG_W-1:0] d);
    @(negedge clock);
    dcr_write = !sel;
    data_config_reg_second_write = sel;
    dcr_data = d;
    data_config_reg_second_data = d;
    @(negedge clock);
    dcr_write = 0;
    data_config_reg_second_write = 0;
    chk(1'h1, (sel ? data_config_reg_second : data_config_reg) === d);
  endtask : wr

  // Waits for a receive clock rise, bounded
  task automatic rx_rise;
    logic p;
    for (int n = 0; n < 20; n++)
    begin
      p = link.rx_bit_clock;
      @(negedge clock);
      if (link.rx_bit_clock && !p)
        return;
    end
    num_errors++;
    $display("unexpected at %0t: receive clock stopped", $time);
    give_verdict();
  endtask : rx_rise

  // One received frame of 64 bit times, optional reject at a bit
  task automatic frame(input logic miss, input logic en, input int rej_at);
    logic e;
    address_filter_match = 1'($random(seed));
    e = en && (address_filter_match ^ miss);
    wr(1'h1, {13'h0000, miss, en, 1'h0});
    carrier_sense_indication = 1;
    if (e)
      notes.push_back(2'h2);
    for (int r = 1; r <= 64; r++)
    begin
      rx_rise();
      if (r == COMP_BIT_INDEX - 2)
        chk(1'h0, link.comp_out);
      if (r == COMP_BIT_INDEX + 2)
        chk(e, link.comp_pin);
      if (r == COMP_BIT_INDEX + 2)
        chk(e, compression_seen);
      if (rej_at > 0 && r == rej_at + 1)
        chk(1'h1, reject_busy);
      reject_request = (r == rej_at);
    end
    if (rej_at > 0)
      notes.push_back(2'h1);
    carrier_sense_indication = 0;
    repeat (8) @(negedge clock);
    chk(1'h0, link.comp_out);
  endtask : frame

  // Main sequence
  initial
  begin
    logic p;
    int n;
    repeat (8) @(negedge clock);
    rst = 0;
    chk(1'h0, link.txc_dev_oe | link.lbk_oe | link.comp_oe);
    wr(1'h0, 16'h0002);
    wr(1'h1, 16'h0001);
    chk(1'h0, link.lbk_oe);
    bus_master = 1;
    repeat (2) @(negedge clock);
    chk(1'h1, link.lbk_pin & link.lbk_oe);
    wr(1'h1, 16'h0000);
    chk(1'h0, link.lbk_pin);
    wr(1'h0, 16'h0004);
    chk(1'h1, link.lbk_pin);
    @(negedge clock);
    chk(1'h1, loopback_seen);
    wr(1'h0, 16'h0000);
    chk(1'h0, link.lbk_pin);
    p = link.txc_pin;
    @(negedge clock);
    chk(!p, link.txc_pin);
    chk(p, mac_tx_clock);
    chk(p, mac_tx_clock_rise);
    // Clock enable low must freeze the pin clock
    ce = 0;
    p = link.txc_pin;
    repeat (3) @(negedge clock);
    chk(p, link.txc_pin);
    ce = 1;
    wr(1'h0, 16'h0001);
    drive_tx_clock = 1;
    chk(1'h0, link.txc_dev_oe);
    n = 0;
    repeat (8)
    begin
      p = mac_tx_clock;
      @(negedge clock);
      n += int'(mac_tx_clock !== p);
    end
    chk(1'h1, n > 0);
    drive_tx_clock = 0;
    wr(1'h0, 16'h0000);
    bus_ordering_select = 1;
    async_bus_mode = 1;
    // Let the released pin be sampled high before the cycle opens
    @(negedge clock);
    cycle_active = 1;
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        notes.push_back(2'h0);
      terminate_request = 1;
      @(negedge clock);
      terminate_request = 0;
      repeat (4) @(negedge clock);
      cycle_active = 0;
    end
    chk(1'h0, link.txc_dev_oe);
    bus_ordering_select = 0;
    async_bus_mode = 0;
    for (int i = 0; i < 5; i++)
      frame(i[1], i != 4, i == 3 ? 20 : (i == 4 ? 59 : 0));
    chk(1'h0, notes.size() != 0);
    give_verdict();
  end
endmodule : mnpc_tb_top
